// [common/spbsr_defs.vh]
`ifndef SPBSR_DEFS_VH
`define SPBSR_DEFS_VH
// ****************************************
// Widths and timing
// ****************************************
`define SPBSR_ADDR_W      18
`define SPBSR_LANES       4
`define SPBSR_LANE_W      9
`define SPBSR_BURST_W     2
// Wake-up after sleep, in cycles
`define SPBSR_WAKE_CYCLES 2
`define SPBSR_WAKE_CNT_W  2
`endif

// [design/spbsr_burst_counter.v]
`timescale 1ns/1ps
// ****************************************
// Two-bit wrapping burst address generator
// ****************************************
module spbsr_burst_counter (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset_n,
    // Control
    input  wire       load,
    input  wire [1:0] start_bits,
    input  wire       advance,
    input  wire       burst_order_sel,
    // Burst address low bits
    output wire [1:0] burst_bits
);
    reg  [1:0] start_reg;
    reg  [1:0] count;

    // Count restarts at each load, then steps only on an advance
    always @(posedge core_clk) begin
        if (!reset_n) begin
            start_reg <= 2'h0;
            count     <= 2'h0;
        end else if (load) begin
            start_reg <= start_bits;
            count     <= 2'h0;
        end else if (advance) begin
            count     <= count + 2'h1;                   // wraps after four
        end
    end

    // Interleaved XORs the count in, linear adds it modulo four
    assign burst_bits = burst_order_sel ? (start_reg ^ count)
                                        : (start_reg + count);
endmodule // spbsr_burst_counter

// [design/spbsr_lane_write.v]
`timescale 1ns/1ps
// ****************************************
// Byte lane write enable decode
// ****************************************
module spbsr_lane_write #(
    parameter LANES = 4
) (
    // Strobes
    input  wire             global_write_n,
    input  wire             lane_write_enable_n,
    input  wire [LANES-1:0] lane_write_n,
    // Per-lane write strobe, active high
    output wire [LANES-1:0] lane_we
);
    genvar i;
    // Global write overrides; otherwise byte enable gates each lane
    generate
        for (i = 0; i < LANES; i = i + 1) begin : g_lane
            assign lane_we[i] = !global_write_n ||
                                (!lane_write_enable_n && !lane_write_n[i]);
        end
    endgenerate
endmodule // spbsr_lane_write

// [design/spbsr_sram_port.v]
`timescale 1ns/1ps
`include "spbsr_defs.vh"
module spbsr_sram_port #(
    parameter ADDR_W = `SPBSR_ADDR_W,
    parameter LANES  = `SPBSR_LANES,
    parameter LANE_W = `SPBSR_LANE_W
) (
    // Clock and reset
    input  wire                      core_clk,
    input  wire                      reset_n,
    // Address and burst control
    input  wire [ADDR_W-1:0]         address,
    input  wire                      proc_addr_strobe_n,
    input  wire                      ctrl_addr_strobe_n,
    input  wire                      burst_advance_n,
    input  wire                      burst_order_sel,
    // Chip selects
    input  wire                      chip_select_first_n,
    input  wire                      chip_select_second,
    input  wire                      chip_select_third_n,
    // Write controls
    input  wire                      global_write_n,
    input  wire                      lane_write_enable_n,
    input  wire [LANES-1:0]          lane_write_n,
    // Output enable and sleep
    input  wire                      output_enable_n,
    input  wire                      sleep_req,
    // Data pins, lane a in the low bits, parity as top bit of each lane
    input  wire [LANES*LANE_W-1:0]   data_in,
    output reg  [LANES*LANE_W-1:0]   data_out,
    output reg  [LANES*LANE_W-1:0]   data_oe
);
    localparam WORD_W = LANES*LANE_W;
    localparam DEPTH  = 1 << ADDR_W;
    // Burst states
    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;

    // ****************************************
    // Storage and pipeline
    // ****************************************
    reg  [WORD_W-1:0]                mem [0:DEPTH-1];
    reg  [1:0]                       state;
    reg  [ADDR_W-1:0]                addr_reg;
    reg  [WORD_W-1:0]                out_stage;
    reg  [WORD_W-1:0]                out_buf;
    reg                              read_valid;
    reg                              buf_valid;
    reg  [1:0]                       sel_pipe;
    reg  [`SPBSR_WAKE_CNT_W-1:0]     wake_cnt;
    wire                             drive_en;
    reg  [WORD_W-1:0]                wr_data;
    reg  [LANES-1:0]                 wr_lanes;
    reg  [ADDR_W-1:0]                wr_addr;

    wire [1:0]                       burst_bits;
    wire [LANES-1:0]                 lane_we;
    wire [ADDR_W-1:0]                cur_addr;
    wire                             awake;
    wire                             chips_on;
    wire                             proc_start;
    wire                             ctrl_start;
    wire                             any_start;
    wire                             deselect;
    wire                             write_now;
    wire                             step;
    wire                             load;

    // ****************************************
    // Cycle decode
    // ****************************************
    // Sleep and its wake-up window freeze everything but stored state
    assign awake      = !sleep_req && (wake_cnt == `SPBSR_WAKE_CNT_W'd0);
    assign chips_on   = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    assign proc_start = awake && !chip_select_first_n && !proc_addr_strobe_n && chips_on;
    // Controller strobe counts only with processor strobe high
    assign ctrl_start = awake && chips_on && !ctrl_addr_strobe_n && proc_addr_strobe_n;
    assign any_start  = proc_start || ctrl_start;
    // A strobe with incomplete selects deselects the part, except a processor strobe with the first select off, which is ignored
    assign deselect   = awake && !any_start &&
                        ((!proc_addr_strobe_n && !chip_select_first_n) || !ctrl_addr_strobe_n);
    // Write inputs ignored on a processor start edge, taken on a controller start
    assign write_now  = awake && !proc_start && (|lane_we) &&
                        (ctrl_start || state != ST_IDLE);
    // Advance ignored on the start edge; high advance is a wait state
    assign step       = awake && !any_start && state != ST_IDLE && !burst_advance_n;
    assign load       = any_start;
    assign cur_addr   = {addr_reg[ADDR_W-1:2], burst_bits};
    // Pins drive only when selected, enabled, awake and not writing
    assign drive_en   = awake && !output_enable_n && !sleep_req && !write_now &&
                        sel_pipe[1] && buf_valid;

    spbsr_lane_write #(
        .LANES               (LANES)
    ) u_lane_write (
        .global_write_n      (global_write_n),
        .lane_write_enable_n (lane_write_enable_n),
        .lane_write_n        (lane_write_n),
        .lane_we             (lane_we)
    );

    spbsr_burst_counter u_burst_counter (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .load                (load),
        .start_bits          (address[1:0]),
        .advance             (step),
        .burst_order_sel     (burst_order_sel),
        .burst_bits          (burst_bits)
    );

    // ****************************************
    // Sleep wake-up counter
    // ****************************************
    // Counter reloads while sleeping and drains after sleep falls
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wake_cnt <= `SPBSR_WAKE_CNT_W'd0;
        end else if (sleep_req) begin
            wake_cnt <= `SPBSR_WAKE_CNT_W'd`SPBSR_WAKE_CYCLES;
        end else if (wake_cnt != `SPBSR_WAKE_CNT_W'd0) begin
            wake_cnt <= wake_cnt - `SPBSR_WAKE_CNT_W'd1;
        end
    end

    // ****************************************
    // Burst state and address register
    // ****************************************
    // Sleep holds every field, so bursts resume where they stopped
    always @(posedge core_clk) begin
        if (!reset_n) begin
            state      <= ST_IDLE;
            addr_reg   <= {ADDR_W{1'b0}};
        end else if (awake) begin
            if (load) begin
                addr_reg <= address;
                state    <= (ctrl_start && (|lane_we)) ? ST_WRITE : ST_READ;
            end else if (deselect) begin
                state    <= ST_IDLE;
            end else if (write_now) begin
                state    <= ST_WRITE;
            end else if (state == ST_WRITE && !burst_advance_n) begin
                state    <= ST_READ;
            end
        end
    end

    // ****************************************
    // Write path
    // ****************************************
    // Data captured into the input register; array update one edge later
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wr_lanes <= {LANES{1'b0}};
            wr_data  <= {WORD_W{1'b0}};
            wr_addr  <= {ADDR_W{1'b0}};
        end else begin
            wr_lanes <= write_now ? lane_we : {LANES{1'b0}};
            if (write_now) begin
                wr_data <= data_in;
                wr_addr <= ctrl_start ? address : cur_addr;
            end
        end
    end

    // Self-timed array write, one lane including parity per strobe
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_wr
            always @(posedge core_clk) begin
                if (wr_lanes[g]) begin
                    mem[wr_addr][g*LANE_W +: LANE_W] <= wr_data[g*LANE_W +: LANE_W];
                end
            end
        end
    endgenerate

    // ****************************************
    // Read pipeline
    // ****************************************
    // Array word to output register, then to output buffer next edge
    always @(posedge core_clk) begin
        if (!reset_n) begin
            out_stage  <= {WORD_W{1'b0}};
            out_buf    <= {WORD_W{1'b0}};
            read_valid <= 1'b0;
            buf_valid  <= 1'b0;
        end else if (awake) begin
            read_valid <= (proc_start || (ctrl_start && !(|lane_we)) ||
                          (state == ST_READ && !write_now && !deselect));
            out_stage  <= mem[load ? address : cur_addr];
            out_buf    <= out_stage;
            buf_valid  <= read_valid;
        end
    end

    // ****************************************
    // Output drive
    // ****************************************
    // Selection seen two edges ago enables, deselection drops in one
    always @(posedge core_clk) begin
        if (!reset_n) begin
            sel_pipe <= 2'h0;
        end else if (awake) begin
            if (deselect) begin
                sel_pipe <= 2'h0;
            end else if (any_start) begin
                sel_pipe <= {sel_pipe[0], 1'b1};
            end else begin
                sel_pipe <= {sel_pipe[0], sel_pipe[0]};
            end
        end
    end

    // Output enable is a level, registered here so outputs come from flops
    always @(posedge core_clk) begin
        if (!reset_n) begin
            data_out <= {WORD_W{1'b0}};
            data_oe  <= {WORD_W{1'b0}};
        end else begin
            // Read data freezes while asleep or waking, so no state is lost
            if (awake) begin
                data_out <= out_buf;
            end
            data_oe  <= {WORD_W{drive_en}};
        end
    end
endmodule // spbsr_sram_port

// [dv/spbsr_port_assertions.sv]
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module spbsr_port_checker #(
    parameter ADDR_W = 18,
    parameter LANES  = 4,
    parameter LANE_W = 9
) (
    // Clock and reset
    input wire                    core_clk,
    input wire                    reset_n,
    // Bus controls
    input wire                    proc_addr_strobe_n,
    input wire                    ctrl_addr_strobe_n,
    input wire                    chip_select_first_n,
    input wire                    chip_select_second,
    input wire                    chip_select_third_n,
    input wire                    global_write_n,
    input wire                    lane_write_enable_n,
    input wire [LANES-1:0]        lane_write_n,
    input wire                    output_enable_n,
    input wire                    sleep_req,
    // Data pins
    input wire [LANES*LANE_W-1:0] data_out,
    input wire [LANES*LANE_W-1:0] data_oe
);
    // Decoded bus states
    wire sel_all = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    wire wr_low  = !global_write_n || (!lane_write_enable_n && !(&lane_write_n));
    wire quiet   = proc_addr_strobe_n && ctrl_addr_strobe_n && !wr_low && !output_enable_n && !sleep_req;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Awake start; the wake window needs two low samples of sleep first
    sequence rd_start;
        !proc_addr_strobe_n && sel_all && !sleep_req && !$past(sleep_req) && !$past(sleep_req, 2);
    endsequence
    a_read_latency: assert property (rd_start ##1 quiet [*3] |=> &data_oe)
        else $error("read data not driven three edges after start");
    a_sleep_quiet: assert property ($past(sleep_req) |-> data_oe == '0)
        else $error("pins driven while asleep");
    a_sleep_holds: assert property ($past(sleep_req) |-> $stable(data_out))
        else $error("read data changed while asleep");
    a_oe_gate: assert property (|data_oe |-> !$past(output_enable_n))
        else $error("pins driven without output enable");
    a_oe_stop: assert property (output_enable_n [*2] |=> data_oe == '0)
        else $error("pins still driven after output enable went high");
    a_write_off: assert property (wr_low && proc_addr_strobe_n && !sleep_req |-> ##1 data_oe == '0)
        else $error("pins driven after a write sample");
    a_deselect_off: assert property (!ctrl_addr_strobe_n && !sel_all |-> ##2 data_oe == '0)
        else $error("pins driven after deselection");
    a_oe_whole: assert property (data_oe == '0 || &data_oe)
        else $error("pin enables split across the bus");
    // Main scenarios
    c_read: cover property (rd_start ##1 quiet [*3]);
    c_write: cover property (!ctrl_addr_strobe_n && proc_addr_strobe_n && wr_low && sel_all);
    c_wake: cover property ($fell(sleep_req));
endmodule // spbsr_port_checker

bind spbsr_sram_port spbsr_port_checker #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_chk (
    .core_clk, .reset_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .chip_select_first_n,
    .chip_select_second, .chip_select_third_n, .global_write_n, .lane_write_enable_n,
    .lane_write_n, .output_enable_n, .sleep_req, .data_out, .data_oe);

// [dv/spbsr_master_bus.sv]
`timescale 1ns/1ps
// ****************************************
// Master side of the shared data pins
// ****************************************
module spbsr_master_bus (
    // Clock
    input  wire        core_clk,
    // Both drivers of the pins
    input  wire [35:0] dev_q,
    input  wire [35:0] dev_oe,
    input  wire [35:0] mst_d,
    input  wire        mst_oe,
    // Resolved level and clash flag
    output wire [35:0] pin,
    output reg         clash
);
    reg [35:0] last = 36'h0;
    initial clash = 1'b0;
    // Undriven bits show the inverse of their last level, so stale data never looks valid
    assign pin = mst_oe ? mst_d : (dev_oe & dev_q) | (~dev_oe & ~last);
    // Both sides driving at once is a contention fault
    always @(posedge core_clk) begin
        last <= pin;
        if (mst_oe && (|dev_oe))
            clash <= 1'b1;
    end
endmodule // spbsr_master_bus

// [dv/tb.sv]
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module tb;
    reg         core_clk;
    reg         reset_n = 1'b0;
    reg  [17:0] address = 18'h0;
    reg         proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1, burst_advance_n = 1'b1;
    reg         burst_order_sel = 1'b0, global_write_n = 1'b1, lane_write_enable_n = 1'b1;
    reg         chip_select_first_n = 1'b0, chip_select_second = 1'b1, chip_select_third_n = 1'b0;
    reg  [3:0]  lane_write_n = 4'hf;
    reg         output_enable_n = 1'b1, sleep_req = 1'b0, mst_oe = 1'b0, live = 1'b1;
    reg  [35:0] mst_d = 36'h0;
    reg  [35:0] mem [0:15];
    wire [35:0] data_in, data_out, data_oe;
    wire        clash;
    integer     n_errors = 0, checks = 0, cycles = 0, i;
    spbsr_sram_port u_dut (.core_clk, .reset_n, .address, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
        .burst_advance_n, .burst_order_sel, .chip_select_first_n, .chip_select_second,
        .chip_select_third_n, .global_write_n, .lane_write_enable_n, .lane_write_n, .output_enable_n,
        .sleep_req, .data_in, .data_out, .data_oe);
    spbsr_master_bus u_bus (.core_clk, .dev_q(data_out), .dev_oe(data_oe), .mst_d, .mst_oe, .pin(data_in), .clash);
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard, far above the roughly one hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    task chk(input [35:0] seen, input [35:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks=%0d errors=%0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Controller-started write; output enable goes high pre cycles before the master drives
    task wr(input [3:0] a, input g, input b, input [3:0] l, input [35:0] d, input integer pre);
        integer k;
        begin
            @(negedge core_clk);
            output_enable_n = 1'b1;
            repeat (pre) @(negedge core_clk);
            address = {14'h0, a};
            ctrl_addr_strobe_n = 1'b0;
            proc_addr_strobe_n = 1'b1;
            global_write_n = g;
            lane_write_enable_n = b;
            lane_write_n = l;
            mst_d = d;
            mst_oe = 1'b1;
            for (k = 0; k < 4; k = k + 1)
                if (live && (!g || (!b && !l[k])))
                    mem[a][9*k +: 9] = d[9*k +: 9];
            @(negedge core_clk);
            ctrl_addr_strobe_n = 1'b1;
            global_write_n = 1'b1;
            lane_write_enable_n = 1'b1;
            lane_write_n = 4'hf;
            mst_oe = 1'b0;
        end
    endtask
    // Processor-started read burst, one wait state, six words checked
    task rd(input [3:0] a, input sel);
        integer j;
        reg [1:0] q [0:9];
        reg [1:0] o;
        begin
            @(negedge core_clk);
            burst_order_sel = sel;
            address = {14'h0, a};
            proc_addr_strobe_n = 1'b0;
            ctrl_addr_strobe_n = 1'b0;
            burst_advance_n = 1'b0;
            global_write_n = 1'b0;
            output_enable_n = 1'b0;
            q[0] = 2'd0;
            for (j = 1; j < 10; j = j + 1) begin
                @(negedge core_clk);
                if (j >= 4) begin
                    o = sel ? a[1:0] ^ q[j-4] : a[1:0] + q[j-4];
                    chk(data_out, mem[{a[3:2], o}]);
                    chk(data_oe, {36{1'b1}});
                end
                proc_addr_strobe_n = 1'b1;
                ctrl_addr_strobe_n = 1'b1;
                global_write_n = 1'b1;
                burst_advance_n = (j == 2);
                q[j] = q[j-1] + (j != 2);
            end
            $display("read burst from %h done", a);
        end
    endtask
    // Sleep mid-burst; writes while asleep and while waking must be lost
    task t_sleep;
        begin
            @(negedge core_clk);
            sleep_req = 1'b1;
            repeat (2) @(negedge core_clk);
            chk(data_oe, 36'h0);
            live = 1'b0;
            wr(4'h5, 1'b0, 1'b1, 4'hf, 36'h123456789, 2);
            @(negedge core_clk);
            sleep_req = 1'b0;
            wr(4'h6, 1'b0, 1'b1, 4'hf, 36'h0abcdef01, 0);
            live = 1'b1;
            repeat (2) @(negedge core_clk);
            rd(4'h5, 1'b1);
            $display("sleep test done");
        end
    endtask
    // Deselect, then a processor strobe with the first select off
    task t_desel;
        begin
            @(negedge core_clk);
            chip_select_second = 1'b0;
            ctrl_addr_strobe_n = 1'b0;
            @(negedge core_clk);
            chip_select_second = 1'b1;
            ctrl_addr_strobe_n = 1'b1;
            @(negedge core_clk);
            chk(data_oe, 36'h0);
            chip_select_first_n = 1'b1;
            proc_addr_strobe_n = 1'b0;
            @(negedge core_clk);
            proc_addr_strobe_n = 1'b1;
            chip_select_first_n = 1'b0;
            repeat (4) begin
                @(negedge core_clk);
                chk(data_oe, 36'h0);
            end
            $display("deselect test done");
        end
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            wr(i[3:0], 1'b0, 1'b1, 4'hf, {9'h1a0 + i[8:0], 9'h0c0 + i[8:0], 9'h150 + i[8:0], 9'h0a5 + i[8:0]}, 2);
        wr(4'h1, 1'b1, 1'b0, 4'b1110, 36'hfffffffff, 2);
        wr(4'h2, 1'b1, 1'b0, 4'b0011, 36'h000000000, 2);
        wr(4'h3, 1'b1, 1'b1, 4'b0000, 36'h000000000, 2);
        wr(4'h4, 1'b0, 1'b0, 4'b1111, 36'h0f0f0f0f0, 2);
        $display("write test done");
        rd(4'h2, 1'b0);
        t_sleep;
        t_desel;
        chk({35'h0, clash}, 36'h0);
        close_out;
    end
endmodule // tb
